// >>> hw/cep_map.svh
// Contract
// - Rank all exceptions in one fixed order
// - Reset pin or power-on raises reset
// - Single step ranks directly below reset
// - Debug pin or break bit raises debug irq
// - Non-maskable line raises its exception
// - Only unmasked interrupt lines raise interrupt
// - Instruction breakpoint match below interrupts
// - Misaligned or protected fetch raises address error
// - Fetch bus error below fetch address error
// - Debug break opcode raises debug breakpoint
// - Service call opcode raises system call
// - Break opcode just below system call
// - Undefined opcode raises reserved instruction
// - Disabled coprocessor instruction raises unusable
// - Disabled extension instruction raises unusable
// - Signed overflow raises overflow exception, on checked instructions only
// - Trap only when condition is true
// - Data address or store value break
// - Misaligned or protected load below data break
// - Misaligned or protected store raises store error
// - Load or store bus error raises fault
// - Load data compare break ranks lowest
`ifndef CEP_MAP_SVH
`define CEP_MAP_SVH

// ==========================================
// Exception codes, priority order
`define CEP_W_CODE      5
`define CEP_N_SRC       23
`define CEP_IRQ_W       8
`define CEP_C_NONE      5'h00
`define CEP_C_RESET     5'h01
`define CEP_C_STEP      5'h02
`define CEP_C_DIRQ      5'h03
`define CEP_C_NMI       5'h04
`define CEP_C_IRQ       5'h05
`define CEP_C_IBRK      5'h06
`define CEP_C_FADDR     5'h07
`define CEP_C_FBUS      5'h08
`define CEP_C_DSWBRK    5'h09
`define CEP_C_SYS       5'h0A
`define CEP_C_BRK       5'h0B
`define CEP_C_UNDEF     5'h0C
`define CEP_C_CPU       5'h0D
`define CEP_C_EXT       5'h0E
`define CEP_C_OVF       5'h0F
`define CEP_C_TRAP      5'h10
`define CEP_C_DABRK     5'h11
`define CEP_C_LADDR     5'h12
`define CEP_C_SADDR     5'h13
`define CEP_C_DBUS      5'h14
`define CEP_C_LDBRK     5'h15

`endif

// >>> hw/cep_pkg.sv
`include "cep_map.svh"

// ==========================================
// Shared types
package cep_pkg;
	typedef logic [`CEP_W_CODE-1:0] cep_code_t;  // Exception code
	typedef logic [`CEP_IRQ_W-1:0]  cep_irq_t;   // Interrupt lines
	typedef logic [`CEP_N_SRC-1:0]  cep_src_t;   // Request vector, bit 0 highest
endpackage : cep_pkg

// >>> hw/cep_prioritizer.sv
`include "cep_map.svh"

// ==========================================
// Exception prioritizer top
module cep_prioritizer (
	input  wire logic          clk,
	input  wire logic          rst,
	// External pins (asynchronous)
	input  wire logic          master_reset_pin,
	input  wire logic          por_pin,
	input  wire logic          nmi_pin,
	input  wire logic          ext_debug_irq_in,
	// Interrupts
	input  wire cep_pkg::cep_irq_t irq_lines,
	input  wire cep_pkg::cep_irq_t irq_mask,
	// Debug control
	input  wire logic          debug_break_req_bit,
	input  wire logic          single_step_req,
	input  wire logic          instr_brk_match,
	// Fetch stage
	input  wire logic          fetch_valid,
	input  wire logic          fetch_misalign,
	input  wire logic          fetch_protected,
	input  wire logic          fetch_bus_err,
	// Execute stage
	input  wire logic          exec_valid,
	input  wire logic          debug_break_opcode,
	input  wire logic          service_call_opcode,
	input  wire logic          break_opcode,
	input  wire logic          undefined_opcode,
	input  wire logic          cop_instr,
	input  wire logic          cop_enabled,
	input  wire logic          ext_instr,
	input  wire logic          ext_enabled,
	input  wire logic          ovf_check_instr,
	input  wire logic          signed_ovf,
	input  wire logic          trap_instr,
	input  wire logic          trap_cond,
	// Memory stage
	input  wire logic          mem_valid,
	input  wire logic          mem_is_store,
	input  wire logic          mem_misalign,
	input  wire logic          mem_protected,
	input  wire logic          data_addr_match,
	input  wire logic          data_value_match,
	input  wire logic          data_bus_err,
	input  wire logic          load_data_match,
	// To the exception sequencer
	output logic               exc_valid,
	output cep_pkg::cep_code_t exc_code,
	output cep_pkg::cep_src_t  exc_pending
);
	import cep_pkg::*;

	// ==========================================
	// Pin synchronisers
	logic mrst_s;  // Reset pin, synchronised
	logic por_s;   // Power-on reset, synchronised
	logic nmi_s;   // Non-maskable line, synchronised
	logic dirq_s;  // Debug interrupt pin, synchronised

	cep_sync u_sync_mrst (
		.clk   (clk),
		.rst   (rst),
		.pin   (master_reset_pin),
		.level (mrst_s)
	);
	cep_sync u_sync_por (
		.clk   (clk),
		.rst   (rst),
		.pin   (por_pin),
		.level (por_s)
	);
	cep_sync u_sync_nmi (
		.clk   (clk),
		.rst   (rst),
		.pin   (nmi_pin),
		.level (nmi_s)
	);
	cep_sync u_sync_dirq (
		.clk   (clk),
		.rst   (rst),
		.pin   (ext_debug_irq_in),
		.level (dirq_s)
	);

	// ==========================================
	// Shared decode helpers

	// Misaligned or protected access; one decode for all three
	// Keeps fetch, load and store address faults in step
	function automatic logic addr_fault(
		input logic misalign,  // Not on its natural boundary
		input logic guarded    // Inside a protected region
	);
		return misalign | guarded;
	endfunction : addr_fault

	// Stage qualifier; a flag left in a bubble stays silent
	// Otherwise a squashed instruction could still raise a fault
	function automatic logic staged(
		input logic valid,  // Stage holds a real instruction
		input logic cond    // Raw condition from that stage
	);
		return valid & cond;
	endfunction : staged

	// ==========================================
	// Event exceptions, ranks 0 to 4
	logic     reset_exc;       // Master reset or power-on reset
	logic     debug_step_exc;  // Single-step stop
	logic     debug_irq_exc;   // Debug interrupt, pin or break bit
	logic     nmi_exc;         // Non-maskable interrupt
	cep_irq_t irq_live;        // Lines left over after the mask
	logic     irq_exc;         // Any unmasked line

	// Reset pin and power-on reset act alike
	// Both pass synchronisers, so a sub-cycle glitch is lost
	always_comb begin
		reset_exc = mrst_s | por_s;
	end

	// Single step stops after the instruction it follows
	// Only reset outranks it
	always_comb begin
		debug_step_exc = single_step_req;
	end

	// Debug pin is synchronised
	// Break bit already lives on this clock
	always_comb begin
		debug_irq_exc = dirq_s | debug_break_req_bit;
	end

	// Non-maskable line
	// No mask bit can hold it back
	always_comb begin
		nmi_exc = nmi_s;
	end

	// A set mask bit hides its line completely
	// Only the remaining lines can raise the exception
	always_comb begin
		irq_live = irq_lines & ~irq_mask;
		irq_exc  = |irq_live;
	end

	// ==========================================
	// Fetch-stage exceptions, ranks 5 to 7
	logic debug_instr_break_exc;  // Instruction breakpoint hit
	logic fetch_addr_exc;         // Misaligned or protected fetch
	logic fetch_bus_fault_exc;    // Bus error on the fetch

	// Instruction breakpoint counts only against a real fetch
	// Ranked below interrupts, above fetch faults
	always_comb begin
		debug_instr_break_exc = staged(fetch_valid, instr_brk_match);
	end

	// Address fault on the fetch address
	always_comb begin
		fetch_addr_exc = staged(fetch_valid,
			addr_fault(fetch_misalign, fetch_protected));
	end

	// Bus error on the fetch
	// Hidden by an address fault above it
	always_comb begin
		fetch_bus_fault_exc = staged(fetch_valid, fetch_bus_err);
	end

	// ==========================================
	// Execute-stage exceptions, ranks 8 to 15
	logic debug_sw_break_exc;      // Debug break opcode
	logic service_exc;             // Service call opcode
	logic break_instr_exc;         // Ordinary break opcode
	logic undefined_opcode_exc;    // Opcode outside the set
	logic cop_off_exc;             // Coprocessor not enabled
	logic disabled_ext_instr_exc;  // Extension not enabled
	logic arith_carry_out_exc;     // Checked signed overflow
	logic condition_check_exc;     // Trap whose condition holds

	// Debug break opcode
	// Highest of the execute-stage faults
	always_comb begin
		debug_sw_break_exc = staged(exec_valid, debug_break_opcode);
	end

	// Service call opcode
	always_comb begin
		service_exc = staged(exec_valid, service_call_opcode);
	end

	// Ordinary break opcode
	// One rank below the service call
	always_comb begin
		break_instr_exc = staged(exec_valid, break_opcode);
	end

	// Opcode the instruction set leaves undefined
	always_comb begin
		undefined_opcode_exc = staged(exec_valid, undefined_opcode);
	end

	// Coprocessor instruction while that coprocessor is off
	// Enabled coprocessor instructions pass untouched
	always_comb begin
		cop_off_exc = staged(exec_valid, cop_instr & ~cop_enabled);
	end

	// Extension instruction while the extension is off
	always_comb begin
		disabled_ext_instr_exc = staged(exec_valid,
			ext_instr & ~ext_enabled);
	end

	// Overflow only on an instruction that asks for the check
	// Wrapping arithmetic overflows silently
	always_comb begin
		arith_carry_out_exc = staged(exec_valid,
			ovf_check_instr & signed_ovf);
	end

	// Trap with a false condition raises nothing
	always_comb begin
		condition_check_exc = staged(exec_valid, trap_instr & trap_cond);
	end

	// ==========================================
	// Memory-stage exceptions, ranks 16 to 20
	logic is_load;                // Access is a load
	logic debug_load_break_exc;   // Address break on a load
	logic debug_store_break_exc;  // Address and value break on a store
	logic load_addr_exc;          // Misaligned or protected load
	logic store_misalign_exc;     // Misaligned or protected store
	logic data_bus_fault_exc;     // Bus error on a load or a store
	logic load_data_break_exc;    // Loaded data hit a breakpoint

	// One direction flag serves loads and stores alike
	always_comb begin
		is_load = ~mem_is_store;
	end

	// A load breaks on its address alone
	always_comb begin
		debug_load_break_exc = staged(mem_valid, is_load & data_addr_match);
	end

	// A store breaks only when address and value both match
	// Address alone is not enough on a store
	always_comb begin
		debug_store_break_exc = staged(mem_valid,
			mem_is_store & data_addr_match & data_value_match);
	end

	// Address fault on a load
	// Ranked below the data address break
	always_comb begin
		load_addr_exc = staged(mem_valid,
			is_load & addr_fault(mem_misalign, mem_protected));
	end

	// Address fault on a store
	always_comb begin
		store_misalign_exc = staged(mem_valid,
			mem_is_store & addr_fault(mem_misalign, mem_protected));
	end

	// Bus error reported for either direction
	// Hidden by any address fault of the same access
	always_comb begin
		data_bus_fault_exc = staged(mem_valid, data_bus_err);
	end

	// Compare of the loaded data, ranked last of all
	// Shows as winner only when nothing else is pending
	always_comb begin
		load_data_break_exc = staged(mem_valid, is_load & load_data_match);
	end

	// ==========================================
	// Request vector, bit index = rank (0 highest)
	cep_src_t req;  // All raw requests

	// Pack the requests in rank order; the two spare bits stay low
	always_comb begin
		req     = '0;
		// Events
		req[0]  = reset_exc;
		req[1]  = debug_step_exc;
		req[2]  = debug_irq_exc;
		req[3]  = nmi_exc;
		req[4]  = irq_exc;
		// Fetch stage
		req[5]  = debug_instr_break_exc;
		req[6]  = fetch_addr_exc;
		req[7]  = fetch_bus_fault_exc;
		// Execute stage
		req[8]  = debug_sw_break_exc;
		req[9]  = service_exc;
		req[10] = break_instr_exc;
		req[11] = undefined_opcode_exc;
		req[12] = cop_off_exc;
		req[13] = disabled_ext_instr_exc;
		req[14] = arith_carry_out_exc;
		req[15] = condition_check_exc;
		// Memory stage
		req[16] = debug_load_break_exc | debug_store_break_exc;
		req[17] = load_addr_exc;
		req[18] = store_misalign_exc;
		req[19] = data_bus_fault_exc;
		req[20] = load_data_break_exc;
	end

	// ==========================================
	// Fixed-priority pick
	function automatic cep_code_t pick(input cep_src_t r);
		cep_code_t c;
		c = `CEP_C_NONE;
		// Scan lowest rank first so highest overwrites
		for (int i = `CEP_N_SRC - 1; i >= 0; i--) begin
			if (r[i]) begin
				c = cep_code_t'(i + 1);
			end
		end
		return c;
	endfunction : pick

	cep_code_t next_code;  // Winning code this cycle

	// Choose the single winner
	always_comb begin
		next_code = pick(req);
	end

	// ==========================================
	// Registered outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			exc_valid <= 1'b0;
			exc_code  <= `CEP_C_NONE;
		end else begin
			exc_valid <= (next_code != `CEP_C_NONE);
			exc_code  <= next_code;
		end
	end

	// Raw pending view for visibility
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			exc_pending <= '0;
		end else begin
			exc_pending <= req;
		end
	end
endmodule : cep_prioritizer

// >>> hw/cep_sync.sv
`include "cep_map.svh"

// ==========================================
// Three-stage pin synchroniser, change on stage 2/3 agreement
module cep_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level
);
	logic s1;  // First stage, read only by s2
	logic s2;  // Second stage
	logic s3;  // Third stage

	// Shift chain
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Accept a change only once stages agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level <= 1'b0;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end
endmodule : cep_sync

// >>> tb/cep_pipe_model.sv
// ==========================================
// Pipeline stand-in: raw stage flags
module cep_pipe_model (
	input  wire logic [43:0] rnd,   // Raw condition bits
	output logic      [43:0] flags  // Stage flags, bench order
);
	import cep_pkg::*;
	// Most flags pass straight through
	assign flags[41:0] = rnd[41:0];
	// Load data compare only on a valid load
	assign flags[42] = rnd[42] & rnd[22] & ~rnd[21];
	// Instruction break only against a valid fetch
	assign flags[43] = rnd[43] & rnd[39];
endmodule : cep_pipe_model

// >>> tb/cep_prioritizer_tb_top.sv
// ==========================================
// Random stage traffic against a noted expectation
module cep_prioritizer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import cep_pkg::*;
	logic clk = 1'b0, rst = 1'b1, arm = 1'b0;
	logic [3:0] pins = 4'h0;
	logic [43:0] rnd = '0;
	wire logic [43:0] flags;
	wire logic master_reset_pin, por_pin, nmi_pin, ext_debug_irq_in, instr_brk_match,
		load_data_match, debug_break_req_bit, single_step_req, fetch_valid, fetch_misalign,
		fetch_protected, fetch_bus_err, exec_valid, debug_break_opcode, service_call_opcode,
		break_opcode, undefined_opcode, cop_instr, cop_enabled, ext_instr, ext_enabled,
		ovf_check_instr, signed_ovf, trap_instr, trap_cond, mem_valid, mem_is_store,
		mem_misalign, mem_protected, data_addr_match, data_value_match, data_bus_err;
	wire cep_irq_t irq_lines, irq_mask;
	logic exc_valid;
	cep_code_t exc_code;
	cep_src_t exc_pending;
	logic [28:0] notes[$];  // Expected answers, oldest first
	int failures = 0, num_checks = 0, cycles = 0;
	assign {master_reset_pin, por_pin, nmi_pin, ext_debug_irq_in} = pins;
	assign {instr_brk_match, load_data_match, debug_break_req_bit, single_step_req, fetch_valid,
		fetch_misalign, fetch_protected, fetch_bus_err, exec_valid, debug_break_opcode,
		service_call_opcode, break_opcode, undefined_opcode, cop_instr, cop_enabled, ext_instr,
		ext_enabled, ovf_check_instr, signed_ovf, trap_instr, trap_cond, mem_valid, mem_is_store,
		mem_misalign, mem_protected, data_addr_match, data_value_match, data_bus_err, irq_mask,
		irq_lines} = flags;
	always #2 clk = ~clk;
	cep_pipe_model cep_pipe_model_inst (.rnd(rnd), .flags(flags));
	cep_prioritizer cep_prioritizer_inst (.*);
	// Expected valid, code and pending from the present inputs
	function automatic logic [28:0] want();
		cep_src_t p;
		cep_code_t c;
		logic f, e, m, s;
		f = fetch_valid;
		e = exec_valid;
		m = mem_valid;
		s = mem_is_store;
		p = '0;
		c = 5'h00;
		p[0] = master_reset_pin | por_pin;
		p[1] = single_step_req;
		p[2] = ext_debug_irq_in | debug_break_req_bit;
		p[3] = nmi_pin;
		p[4] = |(irq_lines & ~irq_mask);
		p[5] = f & instr_brk_match;
		p[6] = f & (fetch_misalign | fetch_protected);
		p[7] = f & fetch_bus_err;
		p[8] = e & debug_break_opcode;
		p[9] = e & service_call_opcode;
		p[10] = e & break_opcode;
		p[11] = e & undefined_opcode;
		p[12] = e & cop_instr & ~cop_enabled;
		p[13] = e & ext_instr & ~ext_enabled;
		p[14] = e & ovf_check_instr & signed_ovf;
		p[15] = e & trap_instr & trap_cond;
		p[16] = m & data_addr_match & (~s | data_value_match);
		p[17] = m & ~s & (mem_misalign | mem_protected);
		p[18] = m & s & (mem_misalign | mem_protected);
		p[19] = m & data_bus_err;
		p[20] = m & ~s & load_data_match;
		for (int i = 22; i >= 0; i--) if (p[i]) c = 5'(i + 1);
		return {|p, c, p};
	endfunction : want
	task automatic check(input string nm, input logic [28:0] seen, input logic [28:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		if (failures == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	// Note each settled input cycle
	always @(posedge clk) begin
		if (arm) notes.push_back(want());
	end
	// Compare each answer with the oldest note
	always @(posedge clk) begin
		#1;
		if (notes.size() > 0) check("exc", {exc_valid, exc_code, exc_pending}, notes.pop_front());
	end
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			tally_and_finish();
		end
	end
	// Pins change every 40 cycles, stage flags every cycle
	initial begin
		void'($urandom(32'h911e));
		repeat (20) @(posedge clk);
		@(negedge clk);
		check("reset", {exc_valid, exc_code, exc_pending}, 29'h0);
		rst = 1'b0;
		for (int i = 0; i < 2000; i++) begin
			@(negedge clk);
			if (i % 40 == 0) for (int b = 0; b < 4; b++) pins[b] = ($urandom % 8) == 0;
			arm = (i % 40) >= 8;
			for (int b = 0; b < 44; b++) rnd[b] = ($urandom % (2 << (i % 4))) == 0;
		end
		@(negedge clk);
		arm = 1'b0;
		repeat (3) @(posedge clk);
		tally_and_finish();
	end
endmodule : cep_prioritizer_tb_top

// >>> tb/cep_properties.sv
// ==========================================
// Exception winner checks
module cep_properties (
	input wire logic               clk,
	input wire logic               rst,
	input wire logic               single_step_req,
	input wire cep_pkg::cep_irq_t  irq_lines,
	input wire cep_pkg::cep_irq_t  irq_mask,
	input wire logic               fetch_valid,
	input wire logic               exec_valid,
	input wire logic               service_call_opcode,
	input wire logic               trap_instr,
	input wire logic               trap_cond,
	input wire logic               exc_valid,
	input wire cep_pkg::cep_code_t exc_code,
	input wire cep_pkg::cep_src_t  exc_pending
);
	import cep_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Service call request in execute
	sequence s_sys;
		exec_valid && service_call_opcode;
	endsequence
	// Any unmasked interrupt line
	sequence s_irq;
		(irq_lines & ~irq_mask) != 8'h00;
	endsequence
	AST_WINNER_TOP: assert property (
		exc_valid |-> exc_pending[exc_code - 5'h01] &&
		(exc_pending & ((23'h1 << (exc_code - 5'h01)) - 23'h1)) == 23'h0)
		else $error("winner is not the top request");
	AST_VALID_CODE: assert property (
		exc_valid == (exc_pending != 23'h0) && exc_pending[22:21] == 2'b00 &&
		(exc_valid || exc_code == 5'h00)) else $error("valid and code disagree");
	AST_SYS_RAISE: assert property (s_sys |=> exc_pending[9])
		else $error("service call missed");
	AST_IRQ_RAISE: assert property (s_irq |=> exc_pending[4])
		else $error("interrupt missed");
	AST_IRQ_MASKED: assert property (
		(irq_lines & ~irq_mask) == 8'h00 |=> !exc_pending[4]) else $error("masked irq seen");
	AST_TRAP_FALSE: assert property (
		exec_valid && trap_instr && !trap_cond |=> !exc_pending[15]) else $error("false trap");
	AST_STEP_RANK: assert property (
		single_step_req |=> exc_pending[1] && exc_code inside {5'h01, 5'h02})
		else $error("single step rank");
	AST_FETCH_GATE: assert property (
		!fetch_valid |=> exc_pending[7:5] == 3'b000) else $error("fetch fault without fetch");
endmodule : cep_properties

bind cep_prioritizer cep_properties cep_properties_inst (.*);
